// ---- design/sbm_bank.sv ----
// Purpose: Per-bank command state machine covering bursts, recovery and row close.
// Assumes: Controller drives command pins on this clock; array read is combinational.
// Notes:   A read burst pauses while the read buffer is full.
`default_nettype none

module sbm_bank
  import sbm_pkg::*;
#(
  parameter logic BANK_ID = 1'b0
) (
  input  wire logic                       core_clk_i,   // Core clock, 50 MHz
  input  wire logic                       rst_b_i,      // Async reset, active low
  input  wire logic                       cs_b_i,       // Chip select, low active
  input  wire logic                       ras_b_i,      // Row strobe, low active
  input  wire logic                       cas_b_i,      // Column strobe, low active
  input  wire logic                       we_b_i,       // Write enable, low active
  input  wire logic                       bank_i,       // Bank select
  input  wire logic                       a10_i,        // Auto-close / all-banks
  input  wire logic [sbm_pkg::COL_W-1:0]  col_i,        // Column address
  input  wire logic [sbm_pkg::DATA_W-1:0] wr_data_i,    // Write data pins
  input  wire logic [sbm_pkg::DATA_W-1:0] arr_rdata_i,  // Array read data
  output logic      [sbm_pkg::COL_W-1:0]  arr_rcol_o,   // Array read column
  output logic                            arr_rd_o,     // Array read strobe
  output logic      [sbm_pkg::COL_W-1:0]  arr_wcol_o,   // Array write column
  output logic      [sbm_pkg::DATA_W-1:0] arr_wdata_o,  // Array write data
  output logic                            arr_we_o,     // Array write strobe
  output logic      [sbm_pkg::DATA_W-1:0] rd_data_o,    // Read data to pins
  output logic                            rd_valid_o,   // Read data valid
  input  wire logic                       rd_ready_i,   // Receiver takes read data
  output sbm_pkg::sbm_state_t             state_o,      // Current bank state
  output logic                            row_open_o,   // Row is open
  output logic                            illegal_o     // Illegal command seen
);

  // ==========================================================
  // Decode
  sbm_cmd_t   cmd;
  sbm_state_t state_q;
  sbm_state_t state_d;
  logic             hit;
  logic             rd_hit;
  logic             wr_hit;
  logic             open_hit;
  logic             close_hit;
  logic             chip_cmd;
  logic             quiet;
  logic             in_rd;
  logic             in_wr;
  logic             step;
  logic             last;
  logic             ld_col;
  logic             ld_tmr;
  logic [TMR_W-1:0] tmr_val;
  logic             tmr_done;
  logic             illegal_d;
  logic             illegal_q;
  logic             row_open_q;
  logic             buf_in_ready;
  logic [COL_W-1:0] col_q;
  logic [BL_W-1:0]  beat_q;
  logic [COL_W-1:0] wcol_q;
  logic [DATA_W-1:0] wdata_q;
  logic             we_q;

  assign cmd       = decode_cmd(cs_b_i, ras_b_i, cas_b_i, we_b_i);  // RULE19
  assign hit       = (bank_i == BANK_ID);
  assign rd_hit    = (cmd == CMD_READ) && hit;
  assign wr_hit    = (cmd == CMD_WRITE) && hit;
  assign open_hit  = (cmd == CMD_OPEN) && hit;
  assign close_hit = (cmd == CMD_CLOSE) && (hit || a10_i);
  assign chip_cmd  = (cmd == CMD_REFR) || (cmd == CMD_MODE);
  assign quiet     = !rd_hit && !wr_hit && !open_hit && !close_hit && !chip_cmd;

  assign in_rd = (state_q == ST_READ) || (state_q == ST_READ_AC);
  assign in_wr = (state_q == ST_WRITE) || (state_q == ST_WRITE_AC);
  // Read beats wait for buffer room so no word is lost
  assign step  = in_rd ? buf_in_ready : in_wr;
  assign last  = step && (beat_q == BL_W'(BURST_LEN - 1));

  function automatic sbm_state_t burst_state(input logic is_wr, input logic ac);
    if (is_wr) return ac ? ST_WRITE_AC : ST_WRITE;
    return ac ? ST_READ_AC : ST_READ;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    state_d   = state_q;
    ld_col    = 1'b0;
    ld_tmr    = 1'b0;
    tmr_val   = '0;
    illegal_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (open_hit) begin
          state_d = ST_ACTIVE;
        end else if (rd_hit || wr_hit) begin
          illegal_d = 1'b1;
        end
        // Idle cycles and halt leave the bank idle  RULE15
      end
      ST_ACTIVE: begin
        if (rd_hit || wr_hit) begin
          state_d = burst_state(wr_hit, a10_i);
          ld_col  = 1'b1;
        end else if (close_hit) begin
          state_d = ST_CLOSING;
          ld_tmr  = 1'b1;
          tmr_val = TMR_W'(ROW_CLOSE_CYC);
        end else if (open_hit || chip_cmd) begin
          illegal_d = 1'b1;
        end
      end
      ST_READ, ST_WRITE: begin
        // Flagged and ignored, so a burst still ends on its last beat
        illegal_d = open_hit || chip_cmd;  // RULE18
        if (rd_hit || wr_hit) begin
          state_d = burst_state(wr_hit, a10_i);  // RULE3 RULE4 RULE8 RULE9
          ld_col  = 1'b1;
        end else if (close_hit) begin
          state_d = ST_CLOSING;  // RULE5 RULE10
          ld_tmr  = 1'b1;
          tmr_val = TMR_W'(ROW_CLOSE_CYC);
        end else if (cmd == CMD_HALT) begin
          state_d = ST_ACTIVE;  // RULE2 RULE7
        end else if (last && state_q == ST_READ) begin
          state_d = ST_ACTIVE;  // RULE1
        end else if (last) begin
          state_d = ST_RECOV;  // RULE6
          ld_tmr  = 1'b1;
          tmr_val = TMR_W'(LAST_DATA_CYC);
        end
      end
      ST_READ_AC, ST_WRITE_AC: begin
        // Flagged, never obeyed: the burst still runs out and closes
        illegal_d = !quiet || (cmd == CMD_HALT);  // RULE11 RULE12
        if (last && state_q == ST_READ_AC) begin
          state_d = ST_CLOSING;  // RULE11
          ld_tmr  = 1'b1;
          tmr_val = TMR_W'(ROW_CLOSE_CYC);
        end else if (last) begin
          state_d = ST_RECOV_AC;  // RULE12
          ld_tmr  = 1'b1;
          tmr_val = TMR_W'(AUTOCLOSE_CYC);
        end
      end
      ST_RECOV: begin
        illegal_d = open_hit || close_hit || chip_cmd;
        if (rd_hit || wr_hit) begin
          state_d = burst_state(wr_hit, a10_i);
          ld_col  = 1'b1;
        end else if (tmr_done) begin
          state_d = ST_ACTIVE;  // RULE16
        end
      end
      ST_RECOV_AC: begin
        illegal_d = !quiet;
        if (tmr_done) begin
          state_d = ST_IDLE;  // RULE17
        end
      end
      ST_CLOSING: begin
        // A repeated close changes nothing  RULE14
        // The timer fires once only, so an illegal access must not hold off the close
        illegal_d = rd_hit || wr_hit || open_hit || chip_cmd;  // RULE14
        if (tmr_done) begin
          state_d = ST_IDLE;  // RULE13
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State and status
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      illegal_q  <= 1'b0;
      row_open_q <= 1'b0;
    end else begin
      illegal_q  <= illegal_d;
      row_open_q <= (state_d != ST_IDLE) && (state_d != ST_CLOSING);
    end
  end

  // ==========================================================
  // Burst column and beat count
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      col_q  <= '0;
      beat_q <= '0;
    end else if (ld_col) begin
      col_q  <= col_i;
      beat_q <= '0;
    end else if (step) begin
      // Sequential order wraps inside the burst-aligned block
      col_q[BL_W-1:0] <= col_q[BL_W-1:0] + BL_W'(1);
      beat_q          <= beat_q + BL_W'(1);
    end
  end

  // ==========================================================
  // Write path, registered toward the array
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      we_q    <= 1'b0;
      wcol_q  <= '0;
      wdata_q <= '0;
    end else begin
      we_q    <= in_wr;
      wcol_q  <= col_q;
      wdata_q <= wr_data_i;
    end
  end

  // ==========================================================
  // Helpers and submodules
  sbm_timer u_timer (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .load_i     (ld_tmr),
    .load_val_i (tmr_val),
    .done_o     (tmr_done)
  );

  sbm_buf2 u_rdbuf (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (in_rd),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (arr_rdata_i),
    .out_valid_o (rd_valid_o),
    .out_ready_i (rd_ready_i),
    .out_data_o  (rd_data_o)
  );

  assign arr_rcol_o  = col_q;
  assign arr_rd_o    = in_rd && buf_in_ready;
  assign arr_wcol_o  = wcol_q;
  assign arr_wdata_o = wdata_q;
  assign arr_we_o    = we_q;
  assign state_o     = state_q;
  assign row_open_o  = row_open_q;
  assign illegal_o   = illegal_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_rd_done;
    (state_q == ST_READ) && quiet && (cmd != CMD_HALT) && last |=> state_q == ST_ACTIVE;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read burst end not active");  // RULE1

  property p_rd_halt;
    (state_q == ST_READ) && (cmd == CMD_HALT) |=> (state_q == ST_ACTIVE) && row_open_o;
  endproperty
  a_rd_halt: assert property (p_rd_halt) else $error("halt did not end read");  // RULE2

  property p_rd_restart;
    (state_q == ST_READ) && rd_hit |=> in_rd && (col_q == $past(col_i)) && (beat_q == '0);
  endproperty
  a_rd_restart: assert property (p_rd_restart) else $error("read restart wrong");  // RULE3

  property p_rd_to_wr;
    (state_q == ST_READ) && wr_hit |=> in_wr ##1 arr_we_o && (arr_wcol_o == $past(col_i, 2));
  endproperty
  a_rd_to_wr: assert property (p_rd_to_wr) else $error("write did not follow read");  // RULE4

  property p_rd_close;
    in_rd && (state_q == ST_READ) && close_hit |=> state_q == ST_CLOSING ##1 !row_open_o;
  endproperty
  a_rd_close: assert property (p_rd_close) else $error("close during read failed");  // RULE5

  property p_wr_done;
    (state_q == ST_WRITE) && quiet && (cmd != CMD_HALT) && last |=> state_q == ST_RECOV;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write end not recovery");  // RULE6

  property p_wr_halt;
    (state_q == ST_WRITE) && (cmd == CMD_HALT) |=> state_q == ST_ACTIVE;
  endproperty
  a_wr_halt: assert property (p_wr_halt) else $error("halt did not end write");  // RULE7

  property p_wr_to_rd;
    (state_q == ST_WRITE) && rd_hit |=> in_rd && (arr_rcol_o == $past(col_i));
  endproperty
  a_wr_to_rd: assert property (p_wr_to_rd) else $error("read did not follow write");  // RULE8

  property p_wr_close;
    (state_q == ST_WRITE) && close_hit |=> (state_q == ST_CLOSING) && !row_open_o;
  endproperty
  a_wr_close: assert property (p_wr_close) else $error("close during write failed");  // RULE10

  property p_rdac_illegal;
    (state_q == ST_READ_AC) && (cmd == CMD_HALT)
      |=> illegal_o && (state_q == ($past(last) ? ST_CLOSING : ST_READ_AC));
  endproperty
  a_rdac_illegal: assert property (p_rdac_illegal) else $error("auto-close read disturbed");  // RULE11

  property p_wrac_recov;
    (state_q == ST_WRITE_AC) && quiet && (cmd != CMD_HALT) && last
      |=> (state_q == ST_RECOV_AC) ##1 (state_q == ST_RECOV_AC) || (state_q == ST_IDLE);
  endproperty
  a_wrac_recov: assert property (p_wrac_recov) else $error("auto-close write recovery");  // RULE12

  property p_close_end;
    (state_q == ST_CLOSING) && tmr_done && !rd_hit && !wr_hit && !open_hit && !chip_cmd
      |=> state_q == ST_IDLE;
  endproperty
  a_close_end: assert property (p_close_end) else $error("row close did not idle");  // RULE13

  property p_close_again;
    (state_q == ST_CLOSING) && close_hit
      |=> !illegal_o && (state_q == ($past(tmr_done) ? ST_IDLE : ST_CLOSING));
  endproperty
  a_close_again: assert property (p_close_again) else $error("repeat close acted");  // RULE14

  property p_idle_quiet;
    (state_q == ST_IDLE) && !open_hit |=> state_q == ST_IDLE;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle bank left idle");  // RULE15

  property p_recov_end;
    (state_q == ST_RECOV) && tmr_done && quiet |=> state_q == ST_ACTIVE;
  endproperty
  a_recov_end: assert property (p_recov_end) else $error("recovery did not reopen");  // RULE16

  property p_dal_end;
    (state_q == ST_RECOV_AC) && tmr_done && quiet |=> state_q == ST_IDLE;
  endproperty
  a_dal_end: assert property (p_dal_end) else $error("auto-close did not idle");  // RULE17

  c_rd_full: cover property ((state_q == ST_READ) ##1 in_rd [*3] ##1 state_q == ST_ACTIVE);
  c_rd_stall: cover property (in_rd && !buf_in_ready);
  c_wrac_idle: cover property ((state_q == ST_RECOV_AC) ##1 state_q == ST_IDLE);

endmodule

`default_nettype wire

// ---- shared/sbm_pkg.sv ----
// Purpose: Constants, command and state types for the bank burst state machine.
// Assumes: Single 50 MHz clock; command pins sampled on every rising edge.
// Notes:   Burst length is fixed; the mode word is handled elsewhere.
//
// Contract
// RULE1: Read burst runs on idle, then row active
// RULE2: Halt ends read burst, row stays active
// RULE3: New read restarts read burst at column
// RULE4: Write interrupts read, starts write burst
// RULE5: Close during read ends burst, closes row
// RULE6: Write burst runs on idle, then recovery
// RULE7: Halt ends write burst, row stays active
// RULE8: Read interrupts write, starts read burst
// RULE9: New write restarts write burst at column
// RULE10: Close during write ends burst, closes row
// RULE11: Auto-close read runs out; others are illegal
// RULE12: Auto-close write recovers, closes; others illegal
// RULE13: Closing bank ignores idle cycles, then idle
// RULE14: Repeat close is no-op; no access meanwhile
// RULE15: Idle bank treats idle cycles as nothing
// RULE16: Write recovery returns to row active
// RULE17: Auto-close write idles after recovery time
// RULE18: No open, refresh or mode during bursts
// RULE19: Commands decoded from strobes; select high deselects
`default_nettype none

package sbm_pkg;

  // ==========================================================
  // Widths and timing
  localparam int CLK_MHZ                 = 50;
  localparam int COL_W                   = 8;
  localparam int DATA_W                  = 16;
  localparam int BL_W                    = 2;
  localparam int BURST_LEN               = 4;
  localparam int TMR_W                   = 4;
  localparam int ROW_CLOSE_NS            = 20;
  localparam int LAST_DATA_TO_CLOSE_NS   = 10;
  localparam int DATA_IN_TO_AUTOCLOSE_NS = 30;

  // Least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ROW_CLOSE_CYC  = ns_to_cyc(ROW_CLOSE_NS);
  localparam int LAST_DATA_CYC  = ns_to_cyc(LAST_DATA_TO_CLOSE_NS);
  localparam int AUTOCLOSE_CYC  = ns_to_cyc(DATA_IN_TO_AUTOCLOSE_NS);

  // ==========================================================
  // Commands and bank states
  typedef enum logic [3:0] {
    CMD_DESELECT = 4'h0, CMD_NOP   = 4'h1, CMD_HALT    = 4'h2,
    CMD_READ     = 4'h3, CMD_WRITE = 4'h4, CMD_OPEN    = 4'h5,
    CMD_CLOSE    = 4'h6, CMD_REFR  = 4'h7, CMD_MODE    = 4'h8
  } sbm_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0, ST_ACTIVE   = 4'h1, ST_READ    = 4'h2,
    ST_WRITE     = 4'h3, ST_READ_AC  = 4'h4, ST_WRITE_AC = 4'h5,
    ST_RECOV     = 4'h6, ST_RECOV_AC = 4'h7, ST_CLOSING = 4'h8
  } sbm_state_t;

  function automatic sbm_cmd_t decode_cmd(input logic cs_b, input logic ras_b,
                                          input logic cas_b, input logic we_b);
    if (cs_b) return CMD_DESELECT;
    unique case ({ras_b, cas_b, we_b})
      3'b111:  return CMD_NOP;
      3'b110:  return CMD_HALT;
      3'b101:  return CMD_READ;
      3'b100:  return CMD_WRITE;
      3'b011:  return CMD_OPEN;
      3'b010:  return CMD_CLOSE;
      3'b001:  return CMD_REFR;
      default: return CMD_MODE;
    endcase
  endfunction

endpackage

`default_nettype wire

// ---- design/sbm_timer.sv ----
// Purpose: Down counter timing a bank's recovery and row-close waits.
// Assumes: Load value is at least one.
// Notes:   Load wins over counting.
`default_nettype none

module sbm_timer
  import sbm_pkg::*;
(
  input  wire logic             core_clk_i,  // Core clock
  input  wire logic             rst_b_i,     // Async reset, active low
  input  wire logic             load_i,      // Start a new wait
  input  wire logic [TMR_W-1:0] load_val_i,  // Cycles to wait
  output logic                  done_o       // Last cycle of the wait
);

  logic [TMR_W-1:0] cnt_q;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= load_val_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - TMR_W'(1);
    end
  end

  assign done_o = (cnt_q == TMR_W'(1));

endmodule

`default_nettype wire

// ---- design/sbm_buf2.sv ----
// Purpose: Two-entry buffer on the read data path.
// Assumes: Same clock on both sides.
// Notes:   Two entries absorb one stall of the receiver without loss.
`default_nettype none

module sbm_buf2
  import sbm_pkg::*;
(
  input  wire logic              core_clk_i,  // Core clock
  input  wire logic              rst_b_i,     // Async reset, active low
  input  wire logic              in_valid_i,  // Word offered
  output logic                   in_ready_o,  // Room for a word
  input  wire logic [DATA_W-1:0] in_data_i,   // Word in
  output logic                   out_valid_o, // Word held
  input  wire logic              out_ready_i, // Receiver takes word
  output logic      [DATA_W-1:0] out_data_o   // Word out
);

  logic [DATA_W-1:0] mem_q [2];
  logic              wr_ptr_q;
  logic              rd_ptr_q;
  logic [1:0]        cnt_q;
  logic              push;
  logic              pop;

  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rd_ptr_q];

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data_i;
        wr_ptr_q        <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

`default_nettype wire

// ---- tb/sbm_array_model.sv ----
// Purpose: Array model that answers the bank's column reads and takes its column writes.
// Assumes: The read answer is combinational on the read column.
// Notes:   Cells start as {~col, col}, so a wrong column shows up in the read data.
`default_nettype none

module sbm_array_model
  import sbm_pkg::*;
(
  input  wire logic                       core_clk_i,  // Core clock
  input  wire logic [sbm_pkg::COL_W-1:0]  rcol_i,      // Read column
  input  wire logic [sbm_pkg::COL_W-1:0]  wcol_i,      // Write column
  input  wire logic [sbm_pkg::DATA_W-1:0] wdata_i,     // Write word
  input  wire logic                       we_i,        // Write strobe
  output logic      [sbm_pkg::DATA_W-1:0] rdata_o      // Read word
);
  timeunit 1ns;
  timeprecision 1ps;
  import sbm_pkg::*;

  logic [DATA_W-1:0] mem [2**COL_W];

  initial for (int i = 0; i < 2**COL_W; i++) mem[i] = {~8'(i), 8'(i)};
  assign rdata_o = mem[rcol_i];
  always @(posedge core_clk_i) if (we_i) mem[wcol_i] <= wdata_i;
endmodule

`default_nettype wire

// ---- tb/tb_sbm_bank.sv ----
// Purpose: Self-checking bench for the bank burst state machine.
// Assumes: The bench plays the controller and drives the pins on the falling edge.
// Notes:   Each scenario starts from reset, so that no bank state leaks from one scenario into the next.
`default_nettype none

module tb_sbm_bank
  import sbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic              core_clk_i = 1'b0;
  logic              rst_b_i    = 1'b0;
  logic              cs_b_i     = 1'b1;
  logic              ras_b_i    = 1'b1;
  logic              cas_b_i    = 1'b1;
  logic              we_b_i     = 1'b1;
  logic              bank_i     = 1'b0;
  logic              a10_i      = 1'b0;
  logic              rd_ready_i = 1'b1;
  logic [COL_W-1:0]  col_i      = '0;
  logic [DATA_W-1:0] wr_data_i  = '0;
  logic [COL_W-1:0]  arr_rcol_o, arr_wcol_o;
  logic [DATA_W-1:0] arr_rdata_i, arr_wdata_o, rd_data_o;
  logic              arr_rd_o, arr_we_o, rd_valid_o, row_open_o, illegal_o;
  sbm_state_t        state_o;
  int                errors     = 0;
  int                n_compared = 0;
  localparam logic [3:0] K_CHIP_DESELECT = 4'hF, K_NOP = 4'h7, K_HALT = 4'h6, K_RD = 4'h5;
  localparam logic [3:0] K_WR = 4'h4, K_OPEN = 4'h3, K_CLOSE = 4'h2;

  always #10 core_clk_i = ~core_clk_i;

  sbm_bank #(.BANK_ID(1'b0)) i_sbm_bank (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .ras_b_i(ras_b_i),
    .cas_b_i(cas_b_i), .we_b_i(we_b_i), .bank_i(bank_i), .a10_i(a10_i), .col_i(col_i),
    .wr_data_i(wr_data_i), .arr_rdata_i(arr_rdata_i), .arr_rcol_o(arr_rcol_o),
    .arr_rd_o(arr_rd_o), .arr_wcol_o(arr_wcol_o), .arr_wdata_o(arr_wdata_o),
    .arr_we_o(arr_we_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .rd_ready_i(rd_ready_i), .state_o(state_o), .row_open_o(row_open_o),
    .illegal_o(illegal_o));

  sbm_array_model i_sbm_array_model (
    .core_clk_i(core_clk_i), .rcol_i(arr_rcol_o), .wcol_i(arr_wcol_o),
    .wdata_i(arr_wdata_o), .we_i(arr_we_o), .rdata_o(arr_rdata_i));

  // ==========================================================
  // Tasks
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic st(input sbm_state_t e);
    chk("state", 16'(e), 16'(state_o));
  endtask

  task automatic cmd(input logic [3:0] k, input logic a = 1'b0, input logic [7:0] c = 8'h00);
    @(negedge core_clk_i);
    {cs_b_i, ras_b_i, cas_b_i, we_b_i} = k;
    a10_i = a;
    col_i = c;
  endtask

  task automatic do_reset();
    @(negedge core_clk_i);
    rst_b_i = 1'b0;
    {cs_b_i, ras_b_i, cas_b_i, we_b_i} = K_NOP;
    repeat (5) @(negedge core_clk_i);
    rst_b_i = 1'b1;
  endtask

  task automatic open_row();
    do_reset();
    rd_ready_i = 1'b1;
    cmd(K_OPEN);
    cmd(K_NOP);
    st(ST_ACTIVE);
  endtask

  // Takes four words; the check comes before each idle cycle, so a word offered now is counted
  task automatic collect(input logic [7:0] c);
    int n;
    n = 0;
    for (int t = 0; t < 30 && n < 4; t++) begin
      if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
        chk("read word", {~{c[7:2], c[1:0] + 2'(n)}, c[7:2], c[1:0] + 2'(n)}, rd_data_o);
        n++;
      end
      cmd(t[0] ? K_CHIP_DESELECT : K_NOP);
    end
    if (n != 4) begin
      errors++;
      $display("unexpected word count expected 4 seen %0d", n);
      end_of_test();
    end
  endtask

  task automatic wait_idle(input int lo, input int hi);
    int t;
    t = 0;
    while (state_o !== ST_IDLE && t < 20) begin
      cmd(K_NOP);
      t++;
    end
    n_compared++;
    if (t < lo || t > hi) begin
      errors++;
      $display("unexpected idle delay expected %0d seen %0d", lo, t);
      if (t == 20) end_of_test();
    end
    chk("row open", 16'h0000, 16'(row_open_o));
  endtask

  // ==========================================================
  // Scenarios; the bench never opens a row or refreshes mid-burst
  task automatic s_idle();
    do_reset();
    cmd(K_CHIP_DESELECT);
    cmd(K_NOP);
    cmd(K_HALT);
    cmd(K_NOP);
    st(ST_IDLE);
    chk("illegal", 16'h0000, 16'(illegal_o));
  endtask

  task automatic s_decode();
    open_row();
    cmd(4'hA);
    cmd(K_NOP);
    st(ST_ACTIVE);
    bank_i = 1'b1;
    cmd(K_RD, 1'b0, 8'h10);
    cmd(K_NOP);
    bank_i = 1'b0;
    st(ST_ACTIVE);
    cmd(4'h1);
    cmd(K_NOP);
    chk("illegal", 16'h0001, 16'(illegal_o));
  endtask

  // The receiver stalls first, so the two-entry buffer fills and the beats pause
  task automatic s_read();
    open_row();
    rd_ready_i = 1'b0;
    cmd(K_RD, 1'b0, 8'h3E);
    repeat (6) cmd(K_NOP);
    st(ST_READ);
    chk("read strobe", 16'h0000, 16'(arr_rd_o));
    chk("read valid", 16'h0001, 16'(rd_valid_o));
    rd_ready_i = 1'b1;
    collect(8'h3E);
    st(ST_ACTIVE);
    chk("row open", 16'h0001, 16'(row_open_o));
  endtask

  task automatic s_intr(input logic [3:0] k1, input logic [3:0] k2, input logic a2,
                        input sbm_state_t e);
    open_row();
    cmd(k1, 1'b0, 8'h10);
    cmd(k2, a2, 8'h26);
    cmd(K_NOP);
    st(e);
    if (k2 == K_RD) chk("read column", 16'h0026, 16'(arr_rcol_o));
    if (k2 == K_WR) begin
      cmd(K_NOP);
      chk("write column", 16'h0026, 16'(arr_wcol_o));
    end
  endtask

  task automatic s_write(input logic a, input logic [7:0] c);
    open_row();
    cmd(K_WR, a, c);
    for (int i = 0; i < 4; i++) begin
      cmd((a && i == 1) ? K_HALT : K_NOP);
      wr_data_i = {c, 8'(i)};
      if (a && i == 2) begin
        chk("illegal", 16'h0001, 16'(illegal_o));
        st(ST_WRITE_AC);
      end
    end
    cmd(K_NOP);
    if (a) begin
      st(ST_RECOV_AC);
      wait_idle(AUTOCLOSE_CYC, AUTOCLOSE_CYC + ROW_CLOSE_CYC);
    end else begin
      st(ST_RECOV);
      repeat (LAST_DATA_CYC) cmd(K_NOP);
      st(ST_ACTIVE);
    end
    for (int i = 0; i < 4; i++) chk("array word", {c, 8'(i)}, i_sbm_array_model.mem[c + i]);
  endtask

  task automatic s_read_ac();
    open_row();
    rd_ready_i = 1'b0;
    cmd(K_RD, 1'b1, 8'h3C);
    cmd(K_CLOSE);
    cmd(K_HALT);
    cmd(K_NOP);
    chk("illegal", 16'h0001, 16'(illegal_o));
    st(ST_READ_AC);
    rd_ready_i = 1'b1;
    collect(8'h3C);
    wait_idle(0, 4);
  endtask

  task automatic s_close();
    open_row();
    cmd(K_CLOSE);
    for (int i = 0; i < ROW_CLOSE_CYC; i++) begin
      cmd(i == 0 ? K_CLOSE : K_HALT);
      st(ST_CLOSING);
    end
    cmd(K_NOP);
    st(ST_IDLE);
    chk("illegal", 16'h0000, 16'(illegal_o));
    open_row();
    cmd(K_CLOSE);
    cmd(K_RD);
    cmd(K_NOP);
    chk("illegal", 16'h0001, 16'(illegal_o));
    st(ST_IDLE);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    s_idle();
    s_decode();
    s_read();
    s_intr(K_RD, K_HALT, 1'b0, ST_ACTIVE);
    s_intr(K_WR, K_HALT, 1'b0, ST_ACTIVE);
    s_intr(K_RD, K_RD, 1'b0, ST_READ);
    s_intr(K_RD, K_RD, 1'b1, ST_READ_AC);
    s_intr(K_RD, K_WR, 1'b0, ST_WRITE);
    s_intr(K_RD, K_WR, 1'b1, ST_WRITE_AC);
    s_intr(K_WR, K_RD, 1'b0, ST_READ);
    s_intr(K_WR, K_RD, 1'b1, ST_READ_AC);
    s_intr(K_WR, K_WR, 1'b0, ST_WRITE);
    s_intr(K_RD, K_CLOSE, 1'b0, ST_CLOSING);
    s_intr(K_WR, K_CLOSE, 1'b1, ST_CLOSING);
    s_write(1'b0, 8'h80);
    s_write(1'b1, 8'h84);
    s_read_ac();
    s_close();
    end_of_test();
  end
endmodule

`default_nettype wire
